// File: design/tpdo_scheduler.v
// transmit process-data scheduler: three channels, timers, register port
// Notes on behaviour
// [R01] default ids base plus node id, writable
// [R02] id bit 31 set disables channel transmit
// [R03] only 11-bit frame format accepted
// [R04] channel 0 valid, channels 1-2 invalid
// [R05] 8-bit transmission type, default 255
// [R06] type 0: on sync, send if changed
// [R07] type 1-240: send every nth sync
// [R08] type 252: latch on sync, send on rtr
// [R09] type 253: refresh and send on rtr
// [R10] 254/255: send on change or event timer
// [R11] inhibit sets minimum spacing, async only
// [R12] change during inhibit waits, sent after
// [R13] inhibit counted in 100 us units
// [R14] inhibit truncated to whole milliseconds
// [R15] inhibit below 10 acts as zero
// [R16] unchanged data resent each event time
// [R17] zero time: send only on change
// [R18] sub-index 4 access is aborted
// [R19] mapping count 0 to 8 entries
// [R20] entry is index, subindex, bit length
// [R21] mapped lengths total at most 8 bytes
// [R22] remap: invalidate, zero, entries, count, valid; the code does not enforce this order and accepts entry writes at any time
// [R23] reserved types 241-251 rejected, kept
// [R24] oversize mapping rejected, left inactive
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "tpdo_defines.vh"

module tpdo_scheduler #(
   parameter MS_CYCLES = `TPDO_MS_NS / `TPDO_CLK_NS
) (
   // clock and reset
   input  wire         sys_clk,
   input  wire         rst,
   // node identity
   input  wire [6:0]   nodeId,
   // register port
   input  wire [7:0]   regAddr,
   input  wire [31:0]  regWdata,
   input  wire         regWr,
   input  wire         regRd,
   output reg  [31:0]  regRdata,
   output reg          regErr,
   // bus events from the receiver
   input  wire         syncPulse,
   input  wire         rtrPulse,
   input  wire [10:0]  rtrId,
   // packed object data per channel, channel 0 in low bits
   input  wire [191:0] chData,
   // frame out
   output reg          txReq,
   output reg  [10:0]  txId,
   output reg  [63:0]  txData,
   output reg  [3:0]   txDlc
);

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // summed bit length of the first n entries
   function [9:0] mapBits;
      input [255:0] m;
      input [3:0]   n;
      integer       k;
      begin
         mapBits = 10'h000;
         for (k = 0; k < 8; k = k + 1) begin
            if (k < n) begin
               mapBits = mapBits + {2'h0, m[32*k +: 8]};  // [R20]
            end
         end
      end
   endfunction

   function [63:0] byteMask;
      input [3:0] dlc;
      integer     k;
      begin
         byteMask = 64'h0;
         for (k = 0; k < 8; k = k + 1) begin
            if (k < dlc) begin
               byteMask[8*k +: 8] = 8'hff;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // millisecond tick and id load after reset

   reg [15:0] msCnt_q;
   reg        msTick_q;
   reg        initDone_q;

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         msCnt_q    <= 16'h0000;
         msTick_q   <= 1'b0;
         initDone_q <= 1'b0;
      end else begin
         initDone_q <= 1'b1;
         msTick_q   <= (msCnt_q == MS_CYCLES[15:0] - 16'h0001);
         if (msCnt_q == MS_CYCLES[15:0] - 16'h0001) begin
            msCnt_q <= 16'h0000;
         end else begin
            msCnt_q <= msCnt_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channels

   wire [2:0]   reqVec;
   wire [2:0]   grantVec;
   wire [2:0]   pendVec;
   wire [2:0]   chErr;
   wire [95:0]  chRd;
   wire [191:0] bufFlat;
   wire [32:0]  idFlat;
   wire [11:0]  dlcFlat;

   // fixed priority: a busy low channel can delay the higher ones
   assign grantVec[0] = reqVec[0];
   assign grantVec[1] = reqVec[1] & ~reqVec[0];
   assign grantVec[2] = reqVec[2] & ~reqVec[1] & ~reqVec[0];

   genvar gi;
   genvar gk;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : ch
         reg [31:0]  map_q [0:7];
         reg         nval_q;
         reg [10:0]  id_q;
         reg [7:0]   type_q;
         reg [15:0]  inhib_q;
         reg [15:0]  event_q;
         reg [3:0]   cnt_q;
         reg [3:0]   dlc_q;
         reg [7:0]   syncCnt_q;
         reg [15:0]  inhTmr_q;
         reg [15:0]  evtTmr_q;
         reg         evtDue_q;
         reg         pend_q;
         reg         rtrArm_q;
         reg         req_q;
         reg [63:0]  last_q;
         reg [63:0]  latch_q;
         reg [63:0]  buf_q;
         reg [31:0]  rd;
         wire [255:0] mapFlat;
         integer     k;

         for (gk = 0; gk < 8; gk = gk + 1) begin : fl
            assign mapFlat[32*gk +: 32] = map_q[gk];
         end

         wire [10:0] base = (gi == 0) ? `TPDO_BASE_CH0 :
                            (gi == 1) ? `TPDO_BASE_CH1 : `TPDO_BASE_CH2;
         wire [5:0]  ofs  = regAddr[5:0];
         wire        sel  = (regAddr[7:6] == gi);
         wire        wrC  = regWr & sel;
         wire [9:0]  newBits = mapBits(mapFlat, regWdata[3:0]);
         wire        badCnt  = (regWdata[7:0] > {4'h0, `TPDO_MAP_MAX}) |
                               (newBits > `TPDO_PAYLOAD_BITS);  // [R21]
         // reserved types are refused so the old type stays in force
         wire        badType = (regWdata[7:0] > `TPDO_TYPE_SYNC_MAX) &
                               (regWdata[7:0] < `TPDO_TYPE_SYNC_RTR);  // [R23]
         wire        badId   = regWdata[`TPDO_BIT_FRAME];
         wire        isMap   = (ofs[5] == 1'b1) & (ofs[1:0] == 2'h0);
         wire        known   = (ofs == `TPDO_OFS_COBID) |
                               (ofs == `TPDO_OFS_TYPE) |
                               (ofs == `TPDO_OFS_INHIB) |
                               (ofs == `TPDO_OFS_EVENT) |
                               (ofs == `TPDO_OFS_COUNT) | isMap;
         // sub-index 4 is not in the known set, so it aborts
         assign chErr[gi] = sel & (regRd | regWr) & (~known |   // [R18]
            (regWr & (ofs == `TPDO_OFS_COBID) & badId) |
            (regWr & (ofs == `TPDO_OFS_TYPE) & badType) |
            (regWr & (ofs == `TPDO_OFS_COUNT) & badCnt));

         // channel sends only while present and mapped
         wire active  = ~nval_q & (cnt_q != 4'h0) & initDone_q; // [R02]
         wire isAsync = (type_q >= `TPDO_TYPE_ASYNC_MIN);         // [R10]
         wire [63:0] live  = chData[64*gi +: 64] & byteMask(dlc_q);
         wire changed = (live != last_q);
         wire rtrHit  = rtrPulse & (rtrId == id_q);
         // integer divide drops the part below one millisecond
         wire [15:0] inhMs = inhib_q / `TPDO_INHIB_PER_MS; // [R13] [R14] [R15]
         wire [7:0]  syncNext = syncCnt_q + 8'h01;
         wire fireS0  = syncPulse & (type_q == 8'h00) & changed;  // [R06]
         wire fireSn  = syncPulse & (type_q != 8'h00) &
                        (type_q <= `TPDO_TYPE_SYNC_MAX) &
                        (syncNext >= type_q);                     // [R07]
         wire fireSr  = rtrHit & rtrArm_q &
                        (type_q == `TPDO_TYPE_SYNC_RTR);          // [R08]
         wire fireR   = rtrHit & (type_q == `TPDO_TYPE_RTR);      // [R09]
         // held change leaves only once the inhibit window is over
         wire fireA   = isAsync & (pend_q | evtDue_q) &
                        (inhTmr_q == 16'h0000);                   // [R11] [R12]
         wire fire    = active & ~req_q &
                        (fireS0 | fireSn | fireSr | fireR | fireA);
         wire [63:0] payload = fireSr ? latch_q : live;

         assign reqVec[gi]          = req_q;
         assign pendVec[gi]         = pend_q;
         assign bufFlat[64*gi +: 64] = buf_q;
         assign idFlat[11*gi +: 11]  = id_q;
         assign dlcFlat[4*gi +: 4]   = dlc_q;
         assign chRd[32*gi +: 32]    = rd;

         always @* begin
            rd = 32'h0;
            case (ofs)
               `TPDO_OFS_COBID: rd = {nval_q, 20'h0, id_q};
               `TPDO_OFS_TYPE:  rd = {24'h0, type_q};
               `TPDO_OFS_INHIB: rd = {16'h0, inhib_q};
               `TPDO_OFS_EVENT: rd = {16'h0, event_q};
               `TPDO_OFS_COUNT: rd = {28'h0, cnt_q};
               default:         rd = isMap ? map_q[ofs[4:2]] : 32'h0;
            endcase
         end

         always @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               for (k = 0; k < 8; k = k + 1) begin
                  map_q[k] <= 32'h0;
               end
               nval_q    <= (gi != 0);                            // [R04]
               id_q      <= 11'h000;
               type_q    <= `TPDO_TYPE_RST;                       // [R05]
               inhib_q   <= 16'h0000;
               event_q   <= 16'h0000;
               cnt_q     <= 4'h0;
               dlc_q     <= 4'h0;
               syncCnt_q <= 8'h00;
               inhTmr_q  <= 16'h0000;
               evtTmr_q  <= 16'h0000;
               evtDue_q  <= 1'b0;
               pend_q    <= 1'b0;
               rtrArm_q  <= 1'b0;
               req_q     <= 1'b0;
               last_q    <= 64'h0;
               latch_q   <= 64'h0;
               buf_q     <= 64'h0;
            end else begin
               // node id is caught in the first cycle after release
               if (~initDone_q) begin
                  id_q <= base + {4'h0, nodeId};                  // [R01]
               end
               if (wrC & ~chErr[gi]) begin
                  case (ofs)
                     `TPDO_OFS_COBID: begin
                        nval_q <= regWdata[`TPDO_BIT_NVALID];     // [R02]
                        id_q   <= regWdata[`TPDO_ID_MSB:0];       // [R01] [R03]
                     end
                     `TPDO_OFS_TYPE: begin
                        type_q    <= regWdata[7:0];               // [R05] [R23]
                        syncCnt_q <= 8'h00;
                     end
                     `TPDO_OFS_INHIB: inhib_q <= regWdata[15:0];
                     `TPDO_OFS_EVENT: event_q <= regWdata[15:0];  // [R16]
                     `TPDO_OFS_COUNT: begin
                        cnt_q <= regWdata[3:0];                   // [R19]
                        dlc_q <= newBits[6:3] + {3'h0, |newBits[2:0]};
                     end
                     default: map_q[ofs[4:2]] <= regWdata;        // [R20]
                  endcase
               end
               if (wrC & chErr[gi] & (ofs == `TPDO_OFS_COUNT)) begin
                  cnt_q <= 4'h0;                                  // [R24]
                  dlc_q <= 4'h0;
               end
               if (syncPulse & (type_q != 8'h00) &
                   (type_q <= `TPDO_TYPE_SYNC_MAX)) begin
                  syncCnt_q <= fireSn ? 8'h00 : syncNext;         // [R07]
               end
               if (syncPulse & (type_q == `TPDO_TYPE_SYNC_RTR)) begin
                  latch_q  <= live;                               // [R08]
                  rtrArm_q <= 1'b1;
               end else if (fireSr) begin
                  rtrArm_q <= 1'b0;
               end
               // inhibit: one extra tick so phase never shortens it
               if (fire & isAsync) begin
                  inhTmr_q <= (inhMs == 16'h0000) ? 16'h0000 :
                              inhMs + 16'h0001;                   // [R11]
               end else if (msTick_q & (inhTmr_q != 16'h0000)) begin
                  inhTmr_q <= inhTmr_q - 16'h0001;
               end
               // event timer restarts at every async send
               if (fire & isAsync) begin
                  evtTmr_q <= event_q;                            // [R16]
               end else if (msTick_q & (evtTmr_q != 16'h0000)) begin
                  evtTmr_q <= evtTmr_q - 16'h0001;
               end else if ((evtTmr_q == 16'h0000) & ~evtDue_q &
                            isAsync & active) begin
                  // an idle timer starts by itself, so a new event time
                  // works without waiting for a data change
                  evtTmr_q <= event_q;                            // [R16]
               end
               if (msTick_q & (evtTmr_q == 16'h0001) &
                   (event_q != 16'h0000) & isAsync & active) begin
                  evtDue_q <= 1'b1;                               // [R16] [R17]
               end else if (fire) begin
                  evtDue_q <= 1'b0;
               end
               // the clear of a send wins over a change in the same cycle
               if (active & isAsync & changed & ~fire) begin
                  pend_q <= 1'b1;                                 // [R12] [R10]
               end else if (fire | ~isAsync) begin
                  pend_q <= 1'b0;
               end
               // queue flag holds one frame until the arbiter takes it
               if (fire) begin
                  last_q <= payload;
                  buf_q  <= payload;
                  req_q  <= 1'b1;
               end else if (grantVec[gi]) begin
                  req_q  <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // frame out and register read

   reg [31:0] rdMux;

   always @* begin
      rdMux = 32'h0;
      case (regAddr[7:6])
         2'h0:    rdMux = chRd[31:0];
         2'h1:    rdMux = chRd[63:32];
         2'h2:    rdMux = chRd[95:64];
         default: rdMux = {24'h0, 1'b0, pendVec, 1'b0, reqVec};
      endcase
   end

   // all frame fields are registered so they change together
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdata <= 32'h0;
         regErr   <= 1'b0;
         txReq    <= 1'b0;
         txId     <= 11'h000;
         txData   <= 64'h0;
         txDlc    <= 4'h0;
      end else begin
         regRdata <= regRd ? rdMux : 32'h0;
         regErr   <= |chErr |
                     (regWr & (regAddr[7:6] == `TPDO_CH_STATUS));
         txReq    <= |grantVec;
         // lowest channel number goes first
         if (grantVec[0]) begin
            txId   <= idFlat[10:0];
            txData <= bufFlat[63:0];
            txDlc  <= dlcFlat[3:0];
         end else if (grantVec[1]) begin
            txId   <= idFlat[21:11];
            txData <= bufFlat[127:64];
            txDlc  <= dlcFlat[7:4];
         end else if (grantVec[2]) begin
            txId   <= idFlat[32:22];
            txData <= bufFlat[191:128];
            txDlc  <= dlcFlat[11:8];
         end
      end
   end

endmodule // tpdo_scheduler

// File: design/tpdo_defines.vh
// constants of the transmit process-data scheduler
`ifndef TPDO_DEFINES_VH
`define TPDO_DEFINES_VH
// channel window: regAddr[7:6] picks channel 0..2, 3 is status
`define TPDO_CH_STATUS  2'h3
`define TPDO_OFS_COBID  6'h00
`define TPDO_OFS_TYPE   6'h04
`define TPDO_OFS_INHIB  6'h08
`define TPDO_OFS_SUB4   6'h0c
`define TPDO_OFS_EVENT  6'h10
`define TPDO_OFS_COUNT  6'h14
`define TPDO_OFS_MAP    6'h20
// identifier word fields
`define TPDO_BIT_NVALID 31
`define TPDO_BIT_FRAME  29
`define TPDO_ID_MSB     10
// reset values
`define TPDO_BASE_CH0   11'h180
`define TPDO_BASE_CH1   11'h280
`define TPDO_BASE_CH2   11'h380
`define TPDO_TYPE_RST   8'hff
// transmission type codes
`define TPDO_TYPE_SYNC_MAX  8'hf0
`define TPDO_TYPE_SYNC_RTR  8'hfc
`define TPDO_TYPE_RTR       8'hfd
`define TPDO_TYPE_ASYNC_MIN 8'hfe
`define TPDO_MAP_MAX        4'h8
`define TPDO_PAYLOAD_BITS   10'h040
// inhibit units per millisecond (100 us units)
`define TPDO_INHIB_PER_MS   16'h000a
// timing
`define TPDO_MS_NS      1000000
`define TPDO_CLK_NS     40
`endif

// File: test/tpdo_props.sv
// assertion checker for the transmit scheduler ports
`include "tpdo_defines.vh"

module tpdo_props #(
   parameter MS_CYCLES = 25000
) (
   // clock and reset
   input logic         sys_clk,
   input logic         rst,
   // register port
   input logic [6:0]   nodeId,
   input logic [7:0]   regAddr,
   input logic [31:0]  regWdata,
   input logic         regWr,
   input logic         regRd,
   input logic [31:0]  regRdata,
   input logic         regErr,
   // bus events and data
   input logic         syncPulse,
   input logic         rtrPulse,
   input logic [10:0]  rtrId,
   input logic [191:0] chData,
   // frame out
   input logic         txReq,
   input logic [10:0]  txId,
   input logic [63:0]  txData,
   input logic [3:0]   txDlc
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   wire [5:0] ofs  = regAddr[5:0];
   wire       chOk = regAddr[7:6] != `TPDO_CH_STATUS;

   sequence sBadType;
      regWr && chOk && ofs == `TPDO_OFS_TYPE
         && regWdata[7:0] > 8'hf0 && regWdata[7:0] < 8'hfc;
   endsequence
   sequence sAbort;
      ##1 regErr;
   endsequence

   ////////////////////////////////////////////////////////////////////////
   AST_SUB4_ABORT: assert property ((regWr || regRd)
      && chOk && ofs == `TPDO_OFS_SUB4 |=> regErr)
      else $error("sub4 not aborted");
   AST_ERR_CAUSE: assert property (
      regErr |-> $past(regWr || regRd)) else $error("abort without access");
   AST_FRAME_29: assert property (regWr && chOk
      && ofs == `TPDO_OFS_COBID && regWdata[29] |=> regErr)
      else $error("long frame format accepted");
   AST_ID_READ: assert property (regRd && chOk
      && ofs == `TPDO_OFS_COBID |=> regRdata[30:11] == 20'h0)
      else $error("id word reserved bits set");
   AST_TYPE_READ: assert property (regRd && chOk
      && ofs == `TPDO_OFS_TYPE |=> regRdata[31:8] == 24'h0)
      else $error("type wider than a byte");
   AST_TYPE_RSVD: assert property (sBadType |-> sAbort)
      else $error("reserved type accepted");
   AST_COUNT_MAX: assert property (regWr && chOk
      && ofs == `TPDO_OFS_COUNT && regWdata[7:0] > 8'h08 |=> regErr)
      else $error("count above eight accepted");
   AST_COUNT_READ: assert property (regRd && chOk
      && ofs == `TPDO_OFS_COUNT |=> regRdata <= 32'h8)
      else $error("count reads above eight");
   AST_DLC_MAX: assert property (txReq |-> txDlc <= 4'h8)
      else $error("frame longer than eight bytes");
   AST_DATA_MASK: assert property (txReq && txDlc < 4'h8
      |-> (txData >> {txDlc, 3'b000}) == 64'h0)
      else $error("bytes beyond length not cleared");
endmodule // tpdo_props

bind tpdo_scheduler tpdo_props #(.MS_CYCLES(MS_CYCLES)) u_tpdo_props (
   .sys_clk(sys_clk), .rst(rst), .nodeId(nodeId), .regAddr(regAddr),
   .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .regErr(regErr), .syncPulse(syncPulse),
   .rtrPulse(rtrPulse), .rtrId(rtrId), .chData(chData), .txReq(txReq),
   .txId(txId), .txData(txData), .txDlc(txDlc));

// File: test/tpdo_master.sv
// bus master model issuing sync and remote request events
module tpdo_master (
   // clock
   input  logic        sys_clk,
   // events toward the node
   output logic        syncPulse,
   output logic        rtrPulse,
   output logic [10:0] rtrId
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      syncPulse = 1'b0;
      rtrPulse = 1'b0;
      rtrId = 11'h7ff;
   end

   task automatic sendSync();
      @(posedge sys_clk);
      syncPulse <= 1'b1;
      @(posedge sys_clk);
      syncPulse <= 1'b0;
   endtask

   // id is inverted once the request is gone so stale ids never match
   task automatic sendRtr(input logic [10:0] id);
      @(posedge sys_clk);
      rtrPulse <= 1'b1;
      rtrId <= id;
      @(posedge sys_clk);
      rtrPulse <= 1'b0;
      rtrId <= ~id;
   endtask
endmodule // tpdo_master

// File: test/tb_tpdo_scheduler.sv
// self-checking bench of the transmit scheduler
module tb_tpdo_scheduler;
   timeunit 1ns;
   timeprecision 1ps;

   logic          sys_clk = 1'b0;
   logic          rst = 1'b1;
   logic [6:0]    nodeId = 7'h05;
   logic [7:0]    regAddr = 8'h00;
   logic [31:0]   regWdata = 32'h0;
   logic          regWr = 1'b0;
   logic          regRd = 1'b0;
   logic [191:0]  chData = {128'h0, 64'h1122334455667788};
   wire  [31:0]   regRdata;
   wire           regErr, syncPulse, rtrPulse, txReq;
   wire  [10:0]   rtrId, txId;
   wire  [63:0]   txData;
   wire  [3:0]    txDlc;
   logic [63:0]   fData;
   logic [10:0]   fId;
   logic [3:0]    fDlc;
   logic [31:0]   rdv;
   logic          er;
   int fail_count = 0, check_count = 0, fcnt = 0, cyc = 0;
   int fCyc, n, m, t, c, i;

   tpdo_scheduler #(.MS_CYCLES(10)) u_tpdo_scheduler (
      .sys_clk(sys_clk), .rst(rst), .nodeId(nodeId), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .regErr(regErr), .syncPulse(syncPulse),
      .rtrPulse(rtrPulse), .rtrId(rtrId), .chData(chData),
      .txReq(txReq), .txId(txId), .txData(txData), .txDlc(txDlc));
   tpdo_master u_tpdo_master (.sys_clk(sys_clk), .syncPulse(syncPulse),
      .rtrPulse(rtrPulse), .rtrId(rtrId));

   initial forever #20 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (txReq === 1'b1) begin
         fcnt <= fcnt + 1;
         fId <= txId;
         fData <= txData;
         fDlc <= txDlc;
         fCyc <= cyc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= w;
      regRd <= ~w;
      @(posedge sys_clk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      #1;
      rdv = regRdata;
      er = regErr;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      acc(1'b0, a, 32'h0);
   endtask
   task automatic chkW(input logic [79:0] got, input logic [79:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chkB(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: flag %b", $time, got);
      end
   endtask
   task automatic waitF(input int k);
      for (int j = 0; j < 300 && fcnt < k; j++) begin
         @(posedge sys_clk);
         #1;
      end
      if (fcnt < k) begin
         fail_count++;
         $display("wrong value at %0t: frame missing", $time);
         end_sim();
      end
   endtask
   task automatic setD(input logic [15:0] v);
      @(posedge sys_clk);
      chData[15:0] <= v;
   endtask
   task automatic cfg0(input logic [7:0] ty);
      wr(8'h00, 32'h8000_0185);
      wr(8'h04, {24'h0, ty});
      wr(8'h08, 32'h0);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h0);
      wr(8'h20, 32'h6041_0010);
      wr(8'h14, 32'h1);
      wr(8'h00, 32'h185);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #1ms;
      fail_count++;
      $display("wrong value at %0t: run timeout", $time);
      end_sim();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(8'h00); chkW(rdv, 32'h185);
      rd(8'h40); chkW(rdv, 32'h8000_0285);
      rd(8'h80); chkW(rdv, 32'h8000_0385);
      rd(8'h04); chkW(rdv, 32'hff);
      rd(8'h0c); chkB(er, 1'b1);
      wr(8'h0c, 32'h1); chkB(er, 1'b1);
      wr(8'h04, 32'hf5); chkB(er, 1'b1);
      rd(8'h04); chkW(rdv, 32'hff);
      wr(8'h00, 32'h2000_0185); chkB(er, 1'b1);
      wr(8'h00, 32'h199); chkB(er, 1'b0);
      rd(8'h00); chkW(rdv, 32'h199);
      wr(8'h94, 32'h9); chkB(er, 1'b1);
      wr(8'ha0, 32'h6064_0040);
      wr(8'ha4, 32'h6041_0008);
      wr(8'h94, 32'h1); chkB(er, 1'b0);
      rd(8'h94); chkW(rdv, 32'h1);
      wr(8'h94, 32'h2); chkB(er, 1'b1);
      rd(8'h94); chkW(rdv, 32'h0);
      cfg0(8'hfd);
      n = fcnt;
      u_tpdo_master.sendRtr(11'h186);
      repeat (6) @(posedge sys_clk);
      chkW(fcnt, n);
      u_tpdo_master.sendRtr(11'h185);
      waitF(n + 1);
      chkW({fId, fDlc, fData}, {11'h185, 4'h2, 64'h7788});
      wr(8'h44, 32'hfd);
      wr(8'h60, 32'h6041_0010);
      wr(8'h54, 32'h1);
      u_tpdo_master.sendRtr(11'h285);
      repeat (6) @(posedge sys_clk);
      chkW(fcnt, n + 1);
      wr(8'h04, 32'h0);
      u_tpdo_master.sendSync();
      repeat (6) @(posedge sys_clk);
      chkW(fcnt, n + 1);
      setD(16'h99aa);
      u_tpdo_master.sendSync();
      waitF(n + 2); chkW(fData, 64'h99aa);
      wr(8'h04, 32'h3);
      repeat (2) u_tpdo_master.sendSync();
      repeat (6) @(posedge sys_clk);
      chkW(fcnt, n + 2);
      u_tpdo_master.sendSync();
      waitF(n + 3); chkW(fData, 64'h99aa);
      wr(8'h04, 32'hfc);
      setD(16'h1234);
      u_tpdo_master.sendSync();
      repeat (6) @(posedge sys_clk);
      chkW(fcnt, n + 3);
      setD(16'h5678);
      u_tpdo_master.sendRtr(11'h185);
      waitF(n + 4); chkW(fData, 64'h1234);
      for (i = 0; i < 2; i++) begin
         wr(8'h04, 32'hfe + i);
         repeat (8) @(posedge sys_clk);
         n = fcnt;
         c = cyc;
         setD(16'hc3c3 + i[15:0]);
         waitF(n + 1);
         chkB((fCyc - c) < 6, 1'b1);
         chkW(fData, 64'hc3c3 + i);
      end
      wr(8'h10, 32'h5);
      waitF(fcnt + 1);
      n = fcnt;
      waitF(n + 1);
      t = fCyc;
      waitF(n + 2);
      chkB((fCyc - t) >= 45 && (fCyc - t) <= 55, 1'b1);
      wr(8'h10, 32'h0);
      wr(8'h08, 32'd37);
      repeat (60) @(posedge sys_clk);
      m = fcnt;
      setD(16'h0a0a);
      waitF(m + 1);
      t = fCyc;
      setD(16'h0b0b);
      waitF(m + 2);
      chkB((fCyc - t) >= 30 && (fCyc - t) <= 43, 1'b1);
      chkW(fData, 64'h0b0b);
      repeat (120) @(posedge sys_clk);
      chkW(fcnt, m + 2);
      wr(8'h08, 32'h5);
      repeat (60) @(posedge sys_clk);
      setD(16'h0c0c);
      waitF(m + 3);
      t = fCyc;
      setD(16'h0d0d);
      waitF(m + 4);
      chkB((fCyc - t) < 8, 1'b1);
      // second reset with another node id: defaults must follow it
      @(posedge sys_clk);
      nodeId <= 7'h22;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rd(8'h00); chkW(rdv, 32'h1a2);
      rd(8'h40); chkW(rdv, 32'h8000_02a2);
      rd(8'h04); chkW(rdv, 32'hff);
      end_sim();
   end
endmodule // tb_tpdo_scheduler
